// ### hw/kmc_pkg.sv
// package for the keypad and indicator controller
// assumes a 50 MHz system clock and an AHB-Lite register slave
package kmc_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned LONG_PRESS_MS   = 2000;
    localparam int unsigned LONG_PRESS_CYC  = (CLK_HZ / 1000) * LONG_PRESS_MS;
    localparam int unsigned DEBOUNCE_US     = 10_000;
    localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned BLINK_MS        = 250;
    localparam int unsigned BLINK_CYC       = (CLK_HZ / 1000) * BLINK_MS;
    localparam int unsigned BOOT_S          = 90;
    // needs 33 bits at the full clock rate
    localparam longint unsigned BOOT_CYC    = 64'(CLK_HZ) * 64'(BOOT_S);
    localparam int unsigned NUM_KEYS        = 10;
    localparam int unsigned NUM_OUTS        = 8;
    localparam int unsigned SAT_TARGET_PCT  = 80;
    localparam int unsigned MOD_STEP_PCT    = 10;
    localparam int unsigned AUTO_STEP_CYC   = 1000;
    // key indices
    localparam int unsigned K_TEACH = 0;
    localparam int unsigned K_AUTO  = 1;
    localparam int unsigned K_INT   = 2;
    localparam int unsigned K_ENTER = 3;
    localparam int unsigned K_OPT   = 4;
    localparam int unsigned K_RIGHT = 5;
    localparam int unsigned K_ABORT = 6;
    localparam int unsigned K_TOL   = 7;
    localparam int unsigned K_CLEAR = 8;
    localparam int unsigned K_LEFT  = 9;
    // register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_INTENS = 8'h08;
    localparam logic [7:0] A_MOD    = 8'h0C;
    localparam logic [7:0] A_ITEM   = 8'h10;
    // reset values
    localparam logic [7:0] MOD_RST    = 8'h32;
    localparam logic [7:0] OUTDEF_RST = 8'hFF;
    // ctrl field positions
    localparam int unsigned C_OVER  = 0;
    localparam int unsigned C_COLOR = 1;
    typedef enum logic [2:0] {
        M_BOOT, M_OPER, M_INT, M_TEACH, M_TOLSUB, M_OPT, M_CLEAR
    } kmc_mode_t;
endpackage : kmc_pkg

// ### hw/kmc_top.sv
// keypad, menu and indicator controller with an AHB-Lite register slave
// assumes keys active high, synchronous to i_clk, one AHB slave on the bus
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
module kmc_top
    import kmc_pkg::*;
#(
    parameter int unsigned LONG_CYC = LONG_PRESS_CYC,
    parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
    parameter int unsigned BLK_CYC  = BLINK_CYC,
    parameter longint unsigned BOOT_LEN = BOOT_CYC
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    // membrane keys
    input  wire logic [NUM_KEYS-1:0] i_keys,
    // colour evaluation
    input  wire logic [NUM_OUTS-1:0] i_color_hit,
    // ahb-lite slave
    input  wire logic                i_hsel,
    input  wire logic [7:0]          i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [31:0]         i_hwdata,
    input  wire logic                i_hready,
    output logic      [31:0]         o_hrdata,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    // indicators and outputs
    output logic [NUM_OUTS-1:0]      o_switch_out,
    output logic [NUM_OUTS-1:0]      o_out_led,
    output logic [NUM_KEYS-1:0]      o_key_led,
    output logic                     o_green_led,
    output logic                     o_red_led,
    output logic                     o_key_lock,
    output logic                     o_teach_evt,
    output logic                     o_clear_evt
);
    typedef struct packed {
        logic [NUM_KEYS-1:0] deb;
        logic [NUM_KEYS-1:0][23:0] dcnt;
        logic [NUM_KEYS-1:0][31:0] hold;
        logic [NUM_KEYS-1:0] longd;
        logic [32:0]         boot;
        logic [31:0]         blk;
        logic                blink;
        kmc_mode_t           mode;
        logic [1:0]          seq;
        logic                lock;
        logic [7:0]          mod;
        logic [7:0]          mod_saved;
        logic [7:0]          intens;
        logic                over;
        logic                autorun;
        logic                autodone;
        logic [15:0]         acnt;
        logic [2:0]          item;
        logic [2:0]          item_saved;
        logic [7:0]          outdef;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic [31:0]         rdata;
        logic [NUM_OUTS-1:0] sw;
        logic [NUM_OUTS-1:0] oled;
        logic [NUM_KEYS-1:0] kled;
        logic                green;
        logic                red;
        logic                tevt;
        logic                cevt;
    } kmc_state_t;

    kmc_state_t st, next_st;

    // thermometer bar of n lit LEDs out of 8
    function automatic logic [NUM_OUTS-1:0] bar(input logic [7:0] pct);
        int unsigned n;
        n = (32'(pct) * 8 + 50) / 100;
        bar = (n >= 8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
    endfunction : bar

    // relative step: below 10 % the level no longer moves
    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        logic [7:0] d;
        d = 8'((16'(v) * 16'(MOD_STEP_PCT)) / 16'd100);
        if (up) begin
            step = (v > 8'd100 - d) ? 8'd100 : v + d;
        end else begin
            step = v - d;
        end
    endfunction : step

    logic [NUM_KEYS-1:0] short_rel, long_hit;
    logic in_menu, bus_req;

    always_comb begin
        next_st      = st;
        next_st.tevt = 1'b0;
        next_st.cevt = 1'b0;
        short_rel    = '0;
        long_hit     = '0;
        in_menu      = (st.mode != M_OPER) && (st.mode != M_BOOT);
        // debounce and press timing
        for (int k = 0; k < NUM_KEYS; k++) begin
            if (i_keys[k] == st.deb[k]) begin
                next_st.dcnt[k] = '0;
            end else if (st.dcnt[k] >= 24'(DEB_CYC - 1)) begin
                next_st.deb[k]  = i_keys[k];
                next_st.dcnt[k] = '0;
            end else begin
                next_st.dcnt[k] = st.dcnt[k] + 24'd1;
            end
            if (st.deb[k]) begin
                if (st.hold[k] != 32'(LONG_CYC)) begin
                    next_st.hold[k] = st.hold[k] + 32'd1;
                end
                if (st.hold[k] == 32'(LONG_CYC - 1)) begin
                    long_hit[k]      = 1'b1;
                    next_st.longd[k] = 1'b1;
                end
            end else begin
                next_st.hold[k]  = '0;
                next_st.longd[k] = 1'b0;
                if (st.hold[k] != 0 && !st.longd[k]) begin
                    short_rel[k] = 1'b1;
                end
            end
        end
        if (st.mode == M_BOOT || st.lock) begin
            long_hit = '0;
        end
        if (st.mode == M_BOOT) begin
            short_rel = '0;
        end
        // lock sequence abort, enter, abort
        if (st.mode != M_BOOT && short_rel != '0) begin
            unique case (st.seq)
                2'd0: next_st.seq = short_rel[K_ABORT] ? 2'd1 : 2'd0;
                2'd1: next_st.seq = short_rel[K_ENTER] ? 2'd2 : (short_rel[K_ABORT] ? 2'd1 : 2'd0);
                2'd2: begin
                    next_st.seq = 2'd0;
                    if (short_rel[K_ABORT]) begin
                        next_st.lock = !st.lock;
                    end
                end
                default: next_st.seq = 2'd0;
            endcase
        end
        if (st.lock) begin
            short_rel = '0;
        end
        // blink and boot timers
        next_st.blk = (st.blk >= 32'(BLK_CYC - 1)) ? '0 : st.blk + 32'd1;
        if (st.blk >= 32'(BLK_CYC - 1)) begin
            next_st.blink = !st.blink;
        end
        if (st.mode == M_BOOT) begin
            next_st.boot = st.boot + 33'd1;
            if (st.boot >= 33'(BOOT_LEN - 1)) begin
                next_st.mode = M_OPER;
            end
        end
        // menu handling
        if (st.mode == M_OPER) begin
            if (long_hit[K_INT]) next_st.mode = M_INT;
            if (long_hit[K_TEACH]) next_st.mode = M_TEACH;
            if (long_hit[K_OPT]) next_st.mode = M_OPT;
            if (long_hit[K_CLEAR]) next_st.mode = M_CLEAR;
            if (long_hit != '0) begin
                next_st.mod_saved  = st.mod;
                next_st.item_saved = st.item;
            end
        end else if (in_menu) begin
            if (long_hit[K_ENTER]) begin
                next_st.mode = M_OPER;
                next_st.autodone = 1'b0;
            end else if (long_hit[K_ABORT]) begin
                next_st.mode     = M_OPER;
                next_st.mod      = st.mod_saved;
                next_st.item     = st.item_saved;
                next_st.autorun  = 1'b0;
                next_st.autodone = 1'b0;
            end
            if (st.mode == M_TEACH && short_rel[K_TOL]) begin
                next_st.mode = M_TOLSUB;
            end
            if (st.mode == M_INT) begin
                if (short_rel[K_RIGHT]) next_st.mod = step(st.mod, 1'b1);
                if (short_rel[K_LEFT]) next_st.mod = step(st.mod, 1'b0);
                if (short_rel[K_AUTO]) begin
                    next_st.autorun  = 1'b1;
                    next_st.autodone = 1'b0;
                end
            end else begin
                if (short_rel[K_RIGHT]) next_st.item = st.item + 3'd1;
                if (short_rel[K_LEFT]) next_st.item = st.item - 3'd1;
                if (short_rel[K_TEACH] || short_rel[K_AUTO]) next_st.tevt = 1'b1;
                if (st.mode == M_CLEAR && short_rel[K_ENTER]) next_st.cevt = 1'b1;
            end
        end
        // auto modulation walks the level to the target
        if (st.autorun) begin
            next_st.acnt = st.acnt + 16'd1;
            if (st.acnt >= 16'(AUTO_STEP_CYC - 1)) begin
                next_st.acnt = '0;
                if (st.mod < 8'(SAT_TARGET_PCT)) next_st.mod = st.mod + 8'd1;
                else if (st.mod > 8'(SAT_TARGET_PCT)) next_st.mod = st.mod - 8'd1;
                else begin
                    next_st.autorun  = 1'b0;
                    next_st.autodone = 1'b1;
                end
            end
        end
        // ahb-lite: latch write address, data in next phase; reads answered at once
        bus_req = i_hsel && i_hready && i_htrans[1];
        if (st.wr_pend) begin
            next_st.wr_pend = 1'b0;
            unique case (st.wr_addr)
                A_CTRL: begin
                    next_st.over = i_hwdata[C_OVER];
                end
                A_INTENS: next_st.intens = i_hwdata[7:0];
                A_MOD: next_st.outdef = i_hwdata[7:0];
                default: ;
            endcase
        end
        if (bus_req) begin
            next_st.wr_pend = i_hwrite;
            next_st.wr_addr = i_haddr;
            unique case (i_haddr)
                A_CTRL:   next_st.rdata = {31'h0, st.over};
                A_STATUS: next_st.rdata = {18'h0, st.lock, st.autodone, st.autorun,
                                           st.item, 2'h0, st.mode, 2'h0, st.mode == M_BOOT};
                A_INTENS: next_st.rdata = {24'h0, st.intens};
                A_MOD:    next_st.rdata = {16'h0, st.outdef, st.mod};
                A_ITEM:   next_st.rdata = {29'h0, st.item};
                default:  next_st.rdata = 32'h0;
            endcase
        end
        // switch outputs and output LEDs live from reset regardless of boot; key LEDs held off during boot
        for (int o = 0; o < NUM_OUTS; o++) begin
            next_st.sw[o] = (i_color_hit == '0) ? st.outdef[o] : i_color_hit[o];
        end
        next_st.oled = next_st.sw;
        if (st.mode == M_INT) begin
            if (st.autorun) next_st.oled = st.blink ? 8'hAA : 8'h55;
            else if (st.autodone) next_st.oled = bar(st.mod);
            else if (st.over) next_st.oled = st.blink ? 8'hFF : 8'h00;
            else next_st.oled = bar(st.intens);
        end
        for (int k = 0; k < NUM_KEYS; k++) begin
            next_st.kled[k] = next_st.longd[k] && st.mode != M_BOOT;
        end
        if (st.mode == M_INT && st.autodone) next_st.kled[K_INT] = 1'b1;
        next_st.green = (st.mode == M_BOOT) ? st.blink : 1'b1;
        next_st.red   = (st.mode == M_BOOT);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st        <= '0;
            st.mode   <= M_BOOT;
            st.mod    <= MOD_RST;
            st.outdef <= OUTDEF_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_hrdata     = st.rdata;
    assign o_hreadyout  = 1'b1;
    assign o_hresp      = 1'b0;
    assign o_switch_out = st.sw;
    assign o_out_led    = st.oled;
    assign o_key_led    = st.kled;
    assign o_green_led  = st.green;
    assign o_red_led    = st.red;
    assign o_key_lock   = st.lock;
    assign o_teach_evt  = st.tevt;
    assign o_clear_evt  = st.cevt;

    property p_boot_leds;
        @(posedge i_clk) disable iff (i_sys_rst) st.mode == M_BOOT |=> o_red_led;
    endproperty
    a_boot_leds: assert property (p_boot_leds) else $error("red off during boot");

    property p_oper_leds;
        @(posedge i_clk) disable iff (i_sys_rst)
            (st.mode == M_OPER && $past(st.mode) == M_OPER) |-> o_green_led && !o_red_led;
    endproperty
    a_oper_leds: assert property (p_oper_leds) else $error("bad leds in operating mode");

    property p_long_led;
        @(posedge i_clk) disable iff (i_sys_rst)
            (long_hit[K_ENTER] && st.mode != M_BOOT) |=> o_key_led[K_ENTER];
    endproperty
    a_long_led: assert property (p_long_led) else $error("key led not lit after long press");

    property p_commit;
        @(posedge i_clk) disable iff (i_sys_rst)
            (in_menu && long_hit[K_ENTER]) |=> st.mode == M_OPER;
    endproperty
    a_commit: assert property (p_commit) else $error("long enter did not leave menu");

    property p_discard;
        @(posedge i_clk) disable iff (i_sys_rst)
            (in_menu && long_hit[K_ABORT] && !st.autorun) |=> st.mod == $past(st.mod_saved);
    endproperty
    a_discard: assert property (p_discard) else $error("long abort kept changes");

    property p_default_out;
        @(posedge i_clk) disable iff (i_sys_rst)
            i_color_hit == '0 |=> o_switch_out == $past(st.outdef);
    endproperty
    a_default_out: assert property (p_default_out) else $error("default outputs wrong");

    property p_auto_flash;
        @(posedge i_clk) disable iff (i_sys_rst)
            (st.mode == M_INT && st.autorun) |=> (o_out_led == 8'hAA || o_out_led == 8'h55);
    endproperty
    a_auto_flash: assert property (p_auto_flash) else $error("auto pattern wrong");

    property p_short_once;
        @(posedge i_clk) disable iff (i_sys_rst) short_rel[K_RIGHT] |=> !short_rel[K_RIGHT];
    endproperty
    a_short_once: assert property (p_short_once) else $error("short action repeated");

    property p_boot_keys;
        @(posedge i_clk) disable iff (i_sys_rst)
            st.mode == M_BOOT |-> long_hit == '0 ##1
                ((st.mode == M_BOOT || st.mode == M_OPER) && !st.lock && o_key_led == '0);
    endproperty
    a_boot_keys: assert property (p_boot_keys) else $error("keys live during boot");
endmodule : kmc_top

// ### bench/kmc_operator.sv
// operator model: presses and releases membrane keys, with optional contact bounce
// assumes tasks are called just after a rising edge of i_clk; released keys read low
module kmc_operator
    import kmc_pkg::*;
(
    // clock
    input  wire logic                i_clk,
    // key levels towards the controller
    output logic      [NUM_KEYS-1:0] o_keys
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_keys = '0;
    // bounce: contact chatters once before it settles, as real membranes do
    task automatic key_down(input int unsigned k, input bit bounce);
        if (bounce) begin
            o_keys[k] <= 1'b1;
            @(posedge i_clk);
            o_keys[k] <= 1'b0;
            @(posedge i_clk);
        end
        o_keys[k] <= 1'b1;
        @(posedge i_clk);
    endtask : key_down
    // release leaves room for debounce and the release action to land
    task automatic key_up(input int unsigned k);
        o_keys[k] <= 1'b0;
        repeat (12) @(posedge i_clk);
    endtask : key_up
    task automatic press(input int unsigned k, input int unsigned n, input bit bounce);
        key_down(k, bounce);
        repeat (n) @(posedge i_clk);
        key_up(k);
    endtask : press
    // spike shorter than the debounce window
    task automatic glitch(input int unsigned k);
        o_keys[k] <= 1'b1;
        repeat (2) @(posedge i_clk);
        key_up(k);
    endtask : glitch
endmodule : kmc_operator

// ### bench/keypad_menu_controller_test.sv
// self-checking bench for the keypad and indicator controller
// assumes shortened counts: long 200, debounce 4, blink 8, boot 100 cycles
module keypad_menu_controller_test
    import kmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LONG_T = 200;
    localparam int unsigned DEB_T  = 4;
    localparam int unsigned BLK_T  = 8;
    logic                i_clk = 1'b0;
    logic                i_sys_rst = 1'b1;
    logic [NUM_KEYS-1:0] keys;
    logic [NUM_OUTS-1:0] i_color_hit = '0;
    logic                i_hsel = 1'b0;
    logic [7:0]          i_haddr = '0;
    logic [1:0]          i_htrans = '0;
    logic                i_hwrite = 1'b0;
    logic [2:0]          i_hsize = 3'b010;
    logic [31:0]         i_hwdata = '0;
    logic [31:0]         o_hrdata;
    logic                o_hreadyout;
    logic [NUM_OUTS-1:0] o_switch_out;
    logic [NUM_OUTS-1:0] o_out_led;
    logic [NUM_KEYS-1:0] o_key_led;
    logic                o_green_led;
    logic                o_red_led;
    logic                o_key_lock;
    logic                o_teach_evt;
    logic                o_clear_evt;
    logic                o_hresp;
    logic [31:0]         rd;
    logic [31:0]         r0;
    logic [2:0]          fl;
    logic [1:0]          seen_g;
    logic [7:0]          hit_tab [5] = '{8'h00, 8'h01, 8'h80, 8'h3C, 8'h00};
    logic [7:0]          exp_tab [5] = '{8'hFF, 8'h01, 8'h80, 8'h3C, 8'h5A};
    int                  err_total = 0;
    int                  samples_checked = 0;
    int                  evt_n = 0;
    int                  clr_n = 0;
    int                  cyc = 0;
    always #10 i_clk = ~i_clk;
    kmc_operator op_u (.i_clk(i_clk), .o_keys(keys));
    kmc_top #(.LONG_CYC(LONG_T), .DEB_CYC(DEB_T), .BLK_CYC(BLK_T), .BOOT_LEN(100)) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_keys(keys), .i_color_hit(i_color_hit),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_switch_out(o_switch_out),
        .o_out_led(o_out_led), .o_key_led(o_key_led), .o_green_led(o_green_led),
        .o_red_led(o_red_led), .o_key_lock(o_key_lock), .o_teach_evt(o_teach_evt),
        .o_clear_evt(o_clear_evt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // one single transfer; called just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        i_hsel   <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr  <= a;
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        q = o_hrdata;
    endtask : bus
    // classify an indicator pattern over three blink half-periods plus four cycles
    task automatic flash_seen(input logic [7:0] a, input logic [7:0] b, output logic [2:0] s);
        s = '0;
        repeat (3 * BLK_T + 4) begin
            @(posedge i_clk);
            if (o_out_led === a) s[0] = 1'b1;
            else if (o_out_led === b) s[1] = 1'b1;
            else s[2] = 1'b1;
        end
    endtask : flash_seen
    task automatic long_press(input int unsigned k);
        op_u.press(k, DEB_T + LONG_T + 40, 1'b1);
    endtask : long_press
    always @(posedge i_clk) begin
        if (!i_sys_rst && o_teach_evt === 1'b1) evt_n++;
        if (!i_sys_rst && o_clear_evt === 1'b1) clr_n++;
    end
    // ceiling covers about 30000 cycles of auto modulation plus margin
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        seen_g = '0;
        repeat (40) begin
            @(posedge i_clk);
            seen_g[o_green_led === 1'b1] = 1'b1;
            chk(o_red_led, 1'b1);
        end
        chk(seen_g, 2'b11);
        chk(o_switch_out, 8'hFF);
        repeat (80) @(posedge i_clk);
        chk({o_green_led, o_red_led}, 2'b10);
        $display("test boot done");
        for (int r = 0; r < 5; r++) begin
            if (r == 4) bus(1'b1, A_MOD, 32'h0000_005A, rd);
            i_color_hit <= hit_tab[r];
            repeat (3) @(posedge i_clk);
            chk(o_switch_out, exp_tab[r]);
            chk(o_out_led, exp_tab[r]);
        end
        bus(1'b0, A_MOD, '0, rd);
        chk(rd, 32'h0000_5A32);
        chk({o_hresp, o_hreadyout}, 2'b01);
        bus(1'b0, 8'h40, '0, rd);
        chk(rd, 32'h0);
        $display("test outputs done");
        op_u.key_down(K_INT, 1'b1);
        repeat (DEB_T + LONG_T - 20) @(posedge i_clk);
        chk(o_key_led[K_INT], 1'b0);
        repeat (40) @(posedge i_clk);
        chk(o_key_led[K_INT], 1'b1);
        repeat (20) @(posedge i_clk);
        chk(o_key_led[K_INT], 1'b1);
        op_u.key_up(K_INT);
        for (int v = 50; v <= 100; v += 50) begin
            bus(1'b1, A_INTENS, v, rd);
            repeat (4) @(posedge i_clk);
            chk(32'($countones(o_out_led)), v * 8 / 100);
        end
        bus(1'b1, A_CTRL, 32'h1, rd);
        flash_seen(8'hFF, 8'h00, fl);
        chk(fl, 3'b011);
        bus(1'b1, A_CTRL, 32'h0, rd);
        op_u.press(K_RIGHT, 20, 1'b1);
        bus(1'b0, A_MOD, '0, rd);
        chk(rd[7:0], 8'd55);
        long_press(K_ABORT);
        bus(1'b0, A_MOD, '0, rd);
        chk(rd[7:0], 8'h32);
        chk({o_green_led, o_red_led}, 2'b10);
        $display("test intensity done");
        long_press(K_INT);
        op_u.press(K_AUTO, 20, 1'b0);
        flash_seen(8'h55, 8'hAA, fl);
        chk(fl, 3'b011);
        rd = '0;
        for (int i = 0; i < 400 && rd[12] !== 1'b1; i++) begin
            repeat (100) @(posedge i_clk);
            bus(1'b0, A_STATUS, '0, rd);
        end
        chk(rd[12], 1'b1);
        bus(1'b0, A_MOD, '0, rd);
        chk(rd[7:0], 8'd80);
        chk(o_key_led[K_INT], 1'b1);
        chk(32'($countones(o_out_led)), 32'd6);
        long_press(K_ENTER);
        bus(1'b0, A_MOD, '0, rd);
        chk(rd[7:0], 8'd80);
        $display("test auto done");
        long_press(K_TEACH);
        evt_n = 0;
        op_u.key_down(K_TEACH, 1'b1);
        repeat (20) @(posedge i_clk);
        chk(evt_n, 0);
        op_u.key_up(K_TEACH);
        chk(evt_n, 1);
        op_u.glitch(K_TEACH);
        chk(evt_n, 1);
        op_u.press(K_AUTO, 20, 1'b1);
        chk(evt_n, 2);
        bus(1'b0, A_ITEM, '0, r0);
        op_u.press(K_RIGHT, 20, 1'b0);
        bus(1'b0, A_ITEM, '0, rd);
        chk(rd[2:0], r0[2:0] + 3'd1);
        op_u.press(K_LEFT, 20, 1'b0);
        bus(1'b0, A_ITEM, '0, rd);
        chk(rd[2:0], r0[2:0]);
        op_u.press(K_TOL, 20, 1'b0);
        bus(1'b0, A_STATUS, '0, rd);
        chk(rd[5:3], M_TOLSUB);
        long_press(K_ABORT);
        long_press(K_CLEAR);
        op_u.press(K_ENTER, 20, 1'b0);
        chk(clr_n, 1);
        long_press(K_ABORT);
        $display("test teach done");
        for (int l = 0; l < 2; l++) begin
            op_u.press(K_ABORT, 20, 1'b0);
            op_u.press(K_ENTER, 20, 1'b0);
            op_u.press(K_ABORT, 20, 1'b0);
            chk(o_key_lock, l == 0);
        end
        op_u.press(K_ABORT, 20, 1'b0);
        op_u.press(K_ENTER, 20, 1'b0);
        op_u.press(K_ABORT, 20, 1'b0);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        i_color_hit <= '0;
        repeat (3) @(posedge i_clk);
        chk({o_key_lock, o_red_led}, 2'b01);
        chk(o_switch_out, 8'hFF);
        $display("test lock and reset done");
        results();
    end
endmodule : keypad_menu_controller_test
